// *** logic/umst_pkg.sv ***
/*
  Shared constants and types for the USART master-SPI transfer block.
  Assumes an 8-bit register port with a 3-bit word address.
*/
`default_nettype none
package umst_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W       = 3;
  localparam logic [2:0]  ADDR_STATUS  = 3'h0;
  localparam logic [2:0]  ADDR_CTRL    = 3'h1;
  localparam logic [2:0]  ADDR_CFG     = 3'h2;
  localparam logic [2:0]  ADDR_BAUD_LO = 3'h3;
  localparam logic [2:0]  ADDR_BAUD_HI = 3'h4;
  localparam logic [2:0]  ADDR_DATA    = 3'h5;

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int unsigned STAT_RXC   = 7;
  localparam int unsigned STAT_TXC   = 6;
  localparam logic [4:0]  STAT_RSV   = 5'h00;
  localparam logic [2:0]  CTRL_FIXED = 3'h6;
  localparam logic [7:0]  CFG_RESET  = 8'h06;
  localparam logic [1:0]  MODE_MSPI  = 2'h3;
  localparam int unsigned BAUD_W     = 12;
  localparam logic [3:0]  LAST_EDGE  = 4'hf;
  localparam int unsigned RX_DEPTH   = 2;
  localparam logic [1:0]  RX_FULL    = 2'h2;

  typedef struct packed {
    logic       rxIrqEn;
    logic       txIrqEn;
    logic       emptyIrqEn;
    logic       rxEnableBit;
    logic       txEnableBit;
    logic [2:0] fixedBits;
  } umst_ctrl_type;

  typedef struct packed {
    logic [1:0] modeSelect;
    logic [2:0] rsv;
    logic       dataOrderBit;
    logic       clockPhaseBit;
    logic       clockPolarityBit;
  } umst_cfg_type;

  typedef enum logic [0:0] {
    ST_IDLE  = 1'b0,
    ST_SHIFT = 1'b1
  } umst_state_type;

endpackage
`default_nettype wire

// *** logic/umst_spi_master.sv ***
/*
  USART in master-SPI mode: double-buffered transmit, two-deep receive
  buffer plus holding slot, baud generator, status/control registers.
  Assumes a same-clock register master; pins go through port logic
  that honours the override outputs.
*/
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Transfers happen only with transmitter enabled; it then owns the data-out pin.
// - Receiver enable is optional and takes over the data-in pin.
// - Transfer clock pin is driven whenever the transmitter is enabled in master SPI mode.
// - Only a data register write starts a transfer.
// - Transmit buffer moves to shifter once the shifter is free.
// - On receive overflow the newest character overwrites the holding slot; the two buffered ones are kept.
// - Frame, overrun and parity error flags always read zero.
// - Receive-complete bit 7 high exactly while unread data exist.
// - Clearing receiver enable flushes receive buffer, dropping receive-complete.
// - Transmit-complete bit 6 sets when frame done and buffer empty.
// - Transmit-complete clears on interrupt execution or writing one.
// - Buffer-empty bit 5 reads one while transmit buffer is empty.
// - Buffer-empty is one after reset.
// - Receive interrupt needs enable bit 7, global flag and flag.
// - Transmit interrupt needs enable bit 6, global flag and flag.
// - Empty interrupt needs enable bit 5, global flag and flag.
// - Control bits 7-3 writable, reset zero; bits 2-0 read 110.
// - Master SPI active only when mode select equals binary 11.
// - Eight data bits; order bit one means LSB first.
// - Polarity sets idle level; phase picks leading or trailing sample.
// - Transfer clock is system clock over two times baud plus one.
module umst_spi_master
  import umst_pkg::*;
(
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              arst_n,
  // Register port
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [7:0]        regWdata,
  input  wire logic              regWrite,
  input  wire logic              regRead,
  output logic      [7:0]        regRdata,
  // Interrupt side
  input  wire logic              globalIntFlag,
  input  wire logic              txCompleteIrqTaken,
  output logic                   rxCompleteIrq,
  output logic                   txCompleteIrq,
  output logic                   bufferEmptyIrq,
  // Serial pins
  input  wire logic              serialInPin,
  output logic                   serialOutPin,
  output logic                   transferClockPin,
  output logic                   serialOutOverride,
  output logic                   serialInOverride,
  output logic                   transferClockOverride
);

  // ----------------------------------------------------------------
  // Reset and input synchronisers
  // ----------------------------------------------------------------
  logic [1:0] rstSync_r;
  logic       rstN;
  logic [1:0] inSync_r;
  logic       serialIn;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) rstSync_r <= 2'h0;
    else         rstSync_r <= {rstSync_r[0], 1'b1};
  end
  assign rstN = rstSync_r[1];

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) inSync_r <= 2'h0;
    else       inSync_r <= {inSync_r[0], serialInPin};
  end
  assign serialIn = inSync_r[1];

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  umst_ctrl_type     ctrl_r;
  umst_cfg_type      cfg_r;
  logic [BAUD_W-1:0] baudSetting_r;
  logic [BAUD_W-1:0] baudCnt_r;
  umst_state_type    state_r;
  logic [3:0]        edgeCnt_r;
  logic [7:0]        txBuf_r;
  logic              txBufValid_r;
  logic [7:0]        txSh_r;
  logic [7:0]        rxSh_r;
  logic              txComplete_r;
  logic              serialOut_r;
  logic              clkLvl_r;
  logic [7:0]        rxMem_r [RX_DEPTH];
  logic              rxRdPtr_r;
  logic              rxWrPtr_r;
  logic [1:0]        rxCnt_r;
  logic [7:0]        rxHold_r;
  logic              rxHoldValid_r;
  logic [7:0]        regRdata_r;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire modeSpi   = (cfg_r.modeSelect == MODE_MSPI);
  wire wrStatus  = regWrite & (regAddr == ADDR_STATUS);
  wire wrCtrl    = regWrite & (regAddr == ADDR_CTRL);
  wire wrCfg     = regWrite & (regAddr == ADDR_CFG);
  wire wrBaudLo  = regWrite & (regAddr == ADDR_BAUD_LO);
  wire wrBaudHi  = regWrite & (regAddr == ADDR_BAUD_HI);
  wire wrData    = regWrite & (regAddr == ADDR_DATA);
  wire rdData    = regRead & (regAddr == ADDR_DATA);
  // Writes while the buffer is full are dropped, as in the plain USART
  wire dataAccept = wrData & modeSpi & ctrl_r.txEnableBit
                    & ~txBufValid_r;
  wire rxc       = (rxCnt_r != 2'h0);
  wire udre      = ~txBufValid_r;
  wire rxPop     = rdData & rxc;

  // ----------------------------------------------------------------
  // Frame sequencing
  // ----------------------------------------------------------------
  wire inFrame   = (state_r == ST_SHIFT);
  wire baudTick  = (baudCnt_r == '0);
  wire edgeEvt   = inFrame & baudTick;
  wire leading   = ~edgeCnt_r[0];
  wire lastEdge  = edgeEvt & (edgeCnt_r == LAST_EDGE);
  wire canLoad   = txBufValid_r & (~inFrame | lastEdge);
  wire cpha      = cfg_r.clockPhaseBit;
  wire lsbFirst  = cfg_r.dataOrderBit;
  wire doSetup   = edgeEvt & (cpha ? leading
                                   : (~leading & ~lastEdge));
  wire doSample  = edgeEvt & (cpha ? ~leading : leading);
  wire txActive  = modeSpi & (ctrl_r.txEnableBit | inFrame
                              | txBufValid_r);

  function automatic logic firstBit(input logic [7:0] d, input logic lsb);
    firstBit = lsb ? d[0] : d[7];
  endfunction

  function automatic logic [7:0] shiftOut(input logic [7:0] d,
                                          input logic lsb);
    shiftOut = lsb ? {1'b0, d[7:1]} : {d[6:0], 1'b0};
  endfunction

  wire [7:0] rxShIn  = lsbFirst ? {serialIn, rxSh_r[7:1]}
                                : {rxSh_r[6:0], serialIn};
  wire [7:0] rxNext  = doSample ? rxShIn : rxSh_r;
  wire       rxDone  = lastEdge & ctrl_r.rxEnableBit;
  wire       rxSpace = (rxCnt_r != RX_FULL) | rxPop;
  wire       pushHold = rxHoldValid_r & rxSpace;
  wire       pushNew  = rxDone & ~rxHoldValid_r & rxSpace;
  wire       rxPush   = pushHold | pushNew;
  wire [7:0] pushByte = pushHold ? rxHold_r : rxNext;

  wire [BAUD_W-1:0] baudCntNxt = (canLoad | edgeEvt) ? baudSetting_r
                                 : (inFrame ? baudCnt_r - 1'b1
                                            : baudCnt_r);

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      state_r   <= ST_IDLE;
      edgeCnt_r <= 4'h0;
      baudCnt_r <= '0;
    end else begin
      baudCnt_r <= baudCntNxt;
      if (canLoad) begin
        state_r   <= ST_SHIFT;
        edgeCnt_r <= 4'h0;
      end else if (lastEdge) begin
        state_r   <= ST_IDLE;
      end else if (edgeEvt) begin
        edgeCnt_r <= edgeCnt_r + 4'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Shifters and pins
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      txSh_r      <= 8'h00;
      rxSh_r      <= 8'h00;
      serialOut_r <= 1'b1;
    end else begin
      rxSh_r <= rxNext;
      if (canLoad) begin
        txSh_r <= cpha ? txBuf_r : shiftOut(txBuf_r, lsbFirst);
        if (!cpha) serialOut_r <= firstBit(txBuf_r, lsbFirst);
      end else if (doSetup) begin
        serialOut_r <= firstBit(txSh_r, lsbFirst);
        txSh_r      <= shiftOut(txSh_r, lsbFirst);
      end
    end
  end

  // Clock level tracks polarity when idle, so a polarity change shows at once
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN)                clkLvl_r <= 1'b0;
    else if (edgeEvt)         clkLvl_r <= ~clkLvl_r;
    else if (!inFrame)        clkLvl_r <= cfg_r.clockPolarityBit;
  end

  assign serialOutPin          = serialOut_r;
  assign transferClockPin      = clkLvl_r;
  assign serialOutOverride     = txActive;
  assign transferClockOverride = txActive;
  assign serialInOverride      = modeSpi & ctrl_r.rxEnableBit;

  // ----------------------------------------------------------------
  // Transmit buffer and flags
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      txBuf_r      <= 8'h00;
      txBufValid_r <= 1'b0;
    end else if (dataAccept) begin
      txBuf_r      <= regWdata;
      txBufValid_r <= 1'b1;
    end else if (canLoad) begin
      txBufValid_r <= 1'b0;
    end
  end

  wire txcSet = lastEdge & ~txBufValid_r;
  wire txcClr = txCompleteIrqTaken
                | (wrStatus & regWdata[STAT_TXC]);

  // Set wins over a clear in the same cycle
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN)       txComplete_r <= 1'b0;
    else if (txcSet) txComplete_r <= 1'b1;
    else if (txcClr) txComplete_r <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Receive buffer
  // ----------------------------------------------------------------
  // Two entries plus a holding slot; a further byte overwrites the slot
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      rxRdPtr_r     <= 1'b0;
      rxWrPtr_r     <= 1'b0;
      rxCnt_r       <= 2'h0;
      rxHoldValid_r <= 1'b0;
      rxHold_r      <= 8'h00;
    end else if (!ctrl_r.rxEnableBit) begin
      rxRdPtr_r     <= 1'b0;
      rxWrPtr_r     <= 1'b0;
      rxCnt_r       <= 2'h0;
      rxHoldValid_r <= 1'b0;
    end else begin
      if (rxPush) rxWrPtr_r <= ~rxWrPtr_r;
      if (rxPop)  rxRdPtr_r <= ~rxRdPtr_r;
      rxCnt_r <= rxCnt_r + {1'b0, rxPush} - {1'b0, rxPop};
      if (rxDone && (rxHoldValid_r || !rxSpace)) begin
        rxHold_r      <= rxNext;
        rxHoldValid_r <= 1'b1;
      end else if (pushHold) begin
        rxHoldValid_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rxPush) rxMem_r[rxWrPtr_r] <= pushByte;
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      ctrl_r        <= umst_ctrl_type'({5'h00, CTRL_FIXED});
      cfg_r         <= umst_cfg_type'(CFG_RESET);
      baudSetting_r <= '0;
    end else begin
      if (wrCtrl)   ctrl_r <= umst_ctrl_type'({regWdata[7:3], CTRL_FIXED});
      if (wrCfg)    cfg_r  <= umst_cfg_type'({regWdata[7:6], 3'h0,
                                             regWdata[2:0]});
      if (wrBaudLo) baudSetting_r[7:0]  <= regWdata;
      if (wrBaudHi) baudSetting_r[11:8] <= regWdata[3:0];
    end
  end

  wire [7:0] statusWord = {rxc, txComplete_r, udre, STAT_RSV};
  wire [7:0] rdMux =
      (regAddr == ADDR_STATUS)  ? statusWord :
      (regAddr == ADDR_CTRL)    ? ctrl_r :
      (regAddr == ADDR_CFG)     ? cfg_r :
      (regAddr == ADDR_BAUD_LO) ? baudSetting_r[7:0] :
      (regAddr == ADDR_BAUD_HI) ? {4'h0, baudSetting_r[11:8]} :
      (regAddr == ADDR_DATA)    ? (rxc ? rxMem_r[rxRdPtr_r] : 8'h00) :
                                  8'h00;

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN)        regRdata_r <= 8'h00;
    else if (regRead) regRdata_r <= rdMux;
  end
  assign regRdata = regRdata_r;

  // ----------------------------------------------------------------
  // Interrupt requests
  // ----------------------------------------------------------------
  assign rxCompleteIrq  = ctrl_r.rxIrqEn & globalIntFlag & rxc;
  assign txCompleteIrq  = ctrl_r.txIrqEn & globalIntFlag & txComplete_r;
  assign bufferEmptyIrq = ctrl_r.emptyIrqEn & globalIntFlag & udre;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstN);

  property p_start_needs_write;
    !inFrame && !txBufValid_r && !dataAccept |=> !inFrame ##1 !inFrame;
  endproperty
  a_start_needs_write: assert property (p_start_needs_write)
    else $error("frame started without a data write");

  property p_empty_drops;
    dataAccept |=> !udre;
  endproperty
  a_empty_drops: assert property (p_empty_drops)
    else $error("buffer-empty still set after accepted write");

  property p_tx_drive;
    serialOutOverride |-> modeSpi;
  endproperty
  a_tx_drive: assert property (p_tx_drive)
    else $error("data-out pin taken outside master SPI mode");

  property p_rx_flush;
    !ctrl_r.rxEnableBit |=> !rxc && !rxCompleteIrq;
  endproperty
  a_rx_flush: assert property (p_rx_flush)
    else $error("receive data kept with receiver disabled");

  property p_txc_set;
    lastEdge && !txBufValid_r |=> txComplete_r && !inFrame;
  endproperty
  a_txc_set: assert property (p_txc_set)
    else $error("transmit-complete not set at end of frame");

  property p_txc_clear;
    wrStatus && regWdata[STAT_TXC] && !txcSet |=> !txComplete_r;
  endproperty
  a_txc_clear: assert property (p_txc_clear)
    else $error("transmit-complete not cleared by write one");

  property p_status_rsv;
    regRead && regAddr == ADDR_STATUS |=> regRdata[4:0] == STAT_RSV;
  endproperty
  a_status_rsv: assert property (p_status_rsv)
    else $error("error flags read nonzero");

  property p_rx_arrive;
    rxDone && rxCnt_r == 2'h0 |=> rxc ##1 (rxc || $past(rxPop));
  endproperty
  a_rx_arrive: assert property (p_rx_arrive)
    else $error("received byte did not raise receive-complete");

  property p_half_period;
    edgeEvt && !lastEdge && baudSetting_r == 12'h003 |=> !edgeEvt [*3] ##1 edgeEvt;
  endproperty
  a_half_period: assert property (p_half_period)
    else $error("half period not baud plus one cycles");

  property p_back_to_back;
    lastEdge && txBufValid_r |=> inFrame && edgeCnt_r == 4'h0;
  endproperty
  a_back_to_back: assert property (p_back_to_back)
    else $error("queued frame not started at once");

  property p_overflow_keeps;
    rxDone && rxCnt_r == RX_FULL && !rxPop |=> $stable(rxCnt_r)
      && rxHoldValid_r && rxMem_r[rxRdPtr_r] == $past(rxMem_r[rxRdPtr_r]);
  endproperty
  a_overflow_keeps: assert property (p_overflow_keeps)
    else $error("older receive data disturbed on overflow");

  property p_irq_gate;
    rxCompleteIrq |-> ctrl_r.rxIrqEn && globalIntFlag && $past(rxc || rxPush);
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("receive interrupt without all conditions");

endmodule
`default_nettype wire

// *** testbench/umst_spi_slave_model.sv ***
/*
  Behavioural SPI slave on the three-wire link of the master block.
  Assumes the bench pulses clr after every mode change, because a change
  of polarity moves the idle clock level and looks like an edge.
*/
`timescale 1ns/1ps
`default_nettype none
module umst_spi_slave_model (
  // Link pins
  input  wire logic       sclk,
  input  wire logic       mosi,
  output logic            miso,
  // Mode as software set it
  input  wire logic       cpol,
  input  wire logic       cpha,
  input  wire logic       lsbFirst,
  input  wire logic       clr,
  // Received frames
  output logic      [7:0] gotByte,
  output int              gotCount
);
  int         edgeNo = 0;
  int         frameNo = 0;
  int         idx;
  logic [7:0] shOut = 8'hc3;
  logic [7:0] shIn;

  // ----------------------------------------------------------------
  // Reply bit: shown at load, moved on each setup edge
  // ----------------------------------------------------------------
  always_comb begin
    idx = cpha ? ((edgeNo == 0) ? 0 : (edgeNo - 1) / 2) : edgeNo / 2;
    miso = shOut[lsbFirst ? idx : 7 - idx];
  end

  // ----------------------------------------------------------------
  // Sample edges, frame end after sixteen edges
  // ----------------------------------------------------------------
  always @(sclk, posedge clr) begin
    if (clr) begin
      edgeNo = 0;
      shOut = 8'hc3 ^ frameNo[7:0];
    end else begin
      if (edgeNo[0] == cpha) rx_bit();
      edgeNo = edgeNo + 1;
      if (edgeNo == 16) begin
        edgeNo = 0;
        frameNo = frameNo + 1;
        gotByte = shIn;
        gotCount = gotCount + 1;
        shOut = 8'hc3 ^ frameNo[7:0];
      end
    end
  end

  task automatic rx_bit();
    shIn[lsbFirst ? edgeNo / 2 : 7 - edgeNo / 2] = mosi;
  endtask
endmodule
`default_nettype wire

// *** testbench/testbench.sv ***
/*
  Self-checking bench for the master-SPI transfer block.
  Assumes the slave model on the link and a 25 MHz system clock.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import umst_pkg::*;
  logic        clock = 1'b0;
  logic        arst_n = 1'b0;
  logic [2:0]  regAddr = 3'h0;
  logic [7:0]  regWdata = 8'h00;
  logic        regWrite = 1'b0;
  logic        regRead = 1'b0;
  logic [7:0]  regRdata;
  logic        globalIntFlag = 1'b0;
  logic        irqTaken = 1'b0;
  logic        rxIrq, txIrq, emptyIrq;
  logic        miso, mosi, sclk, outOvr, inOvr, clkOvr;
  logic        cpol = 1'b0, cpha = 1'b0, lsbFirst = 1'b0, clr = 1'b1;
  logic [7:0]  gotByte, v, b;
  int          gotCount, failures = 0, num_checks = 0, i, m;
  logic [31:0] seed = 32'h99b9;
  logic [8:0]  expRd[$];
  logic [7:0]  expWire[$], rxQ[$];
  logic        rdPend = 1'b0;
  time         lastEdge = 0;
  time         dt;
  int          baud = 3;
  int          frameNo = 0;

  always #20 clock = ~clock;

  umst_spi_master u_dut (.clock(clock), .arst_n(arst_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .globalIntFlag(globalIntFlag), .txCompleteIrqTaken(irqTaken),
    .rxCompleteIrq(rxIrq), .txCompleteIrq(txIrq), .bufferEmptyIrq(emptyIrq),
    .serialInPin(miso), .serialOutPin(mosi), .transferClockPin(sclk),
    .serialOutOverride(outOvr), .serialInOverride(inOvr), .transferClockOverride(clkOvr));

  umst_spi_slave_model u_slave (.sclk(sclk), .mosi(mosi), .miso(miso), .cpol(cpol),
    .cpha(cpha), .lsbFirst(lsbFirst), .clr(clr), .gotByte(gotByte), .gotCount(gotCount));

  // ----------------------------------------------------------------
  // Comparison, verdict and watchers
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge clock) begin
    if (rdPend && expRd.size() > 0 && expRd[0][8]) chk("read data", regRdata, expRd[0][7:0]);
    if (rdPend && expRd.size() > 0) void'(expRd.pop_front());
    rdPend <= regRead;
  end

  // A frame nobody asked for means something other than a data write started it
  always @(gotCount) begin
    #1;
    if (expWire.size() == 0) chk("spurious frame", gotByte, 8'hxx);
    else chk("mosi byte", gotByte, expWire.pop_front());
  end

  // Gaps of two half periods or more are idle time and are not judged
  always @(sclk) begin
    dt = $time - lastEdge;
    lastEdge = $time;
    if (arst_n && dt < 320) chk("half period", 8'(dt / 40), 8'(baud + 1));
  end

  initial begin
    #800000;
    failures++;
    tally_and_finish();
  end

  // ----------------------------------------------------------------
  // Register bus tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, input logic [8:0] e, output logic [7:0] d);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'b1;
    expRd.push_back(e);
    @(posedge clock);
    regRead <= 1'b0;
    #1 d = regRdata;
  endtask

  task automatic rc(input logic [2:0] a, input logic [7:0] e);
    rd(a, {1'b1, e}, v);
  endtask

  task automatic poll(input int bitNo);
    v = 8'h00;
    for (int k = 0; k < 100 && v[bitNo] !== 1'b1; k++) rd(ADDR_STATUS, 9'h000, v);
  endtask

  task automatic send();
    b = 8'($random(seed));
    wr(ADDR_DATA, b);
    expWire.push_back(b);
    rxQ.push_back(8'hc3 ^ frameNo[7:0]);
    frameNo++;
  endtask

  task automatic set_mode(input int md);
    cpol <= md[0];
    cpha <= md[1];
    lsbFirst <= md[2];
    wr(ADDR_CFG, {MODE_MSPI, 3'h0, md[2], md[1], md[0]});
    @(posedge clock);
    clr <= 1'b1;
    @(posedge clock);
    clr <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clock);
    arst_n <= 1'b1;
    repeat (4) @(posedge clock);
    clr <= 1'b0;
    rc(ADDR_STATUS, 8'h20);
    rc(ADDR_CTRL, 8'h06);
    rc(ADDR_CFG, CFG_RESET);
    rc(3'h7, 8'h00);
    wr(ADDR_CTRL, 8'hff);
    rc(ADDR_CTRL, 8'hfe);
    wr(ADDR_CTRL, 8'h18);
    wr(ADDR_DATA, 8'h5a);
    repeat (80) @(posedge clock);
    chk("override outside spi mode", 8'(clkOvr), 8'h00);
    rc(ADDR_STATUS, 8'h20);
    wr(ADDR_BAUD_LO, 8'(baud));
    wr(ADDR_BAUD_HI, 8'h00);
    for (m = 0; m < 8; m++) begin
      set_mode(m);
      chk("out override", 8'({outOvr, clkOvr, inOvr}), 8'h07);
      chk("idle clock", 8'(sclk), 8'(cpol));
      send();
      poll(STAT_TXC);
      rc(ADDR_STATUS, 8'he0);
      wr(ADDR_STATUS, 8'h40);
      rc(ADDR_DATA, rxQ.pop_front());
      rc(ADDR_STATUS, 8'h20);
      chk("idle clock after frame", 8'(sclk), 8'(cpol));
    end
    set_mode(0);
    send();
    repeat (4) @(posedge clock);
    rc(ADDR_STATUS, 8'h20);
    send();
    rc(ADDR_STATUS, 8'h00);
    for (i = 0; i < 2; i++) begin
      poll(5);
      send();
    end
    poll(STAT_TXC);
    rc(ADDR_DATA, rxQ.pop_front());
    rc(ADDR_DATA, rxQ.pop_front());
    void'(rxQ.pop_front());
    rc(ADDR_DATA, rxQ.pop_front());
    rc(ADDR_STATUS, 8'h60);
    rc(ADDR_DATA, 8'h00);
    wr(ADDR_STATUS, 8'h40);
    send();
    poll(STAT_TXC);
    wr(ADDR_CTRL, 8'h08);
    @(posedge clock);
    chk("in override", 8'(inOvr), 8'h00);
    rc(ADDR_STATUS, 8'h60);
    void'(rxQ.pop_front());
    wr(ADDR_CTRL, 8'h18);
    wr(ADDR_STATUS, 8'h40);
    send();
    poll(STAT_TXC);
    wr(ADDR_CTRL, 8'hf8);
    for (i = 0; i < 2; i++) begin
      globalIntFlag <= i[0];
      repeat (2) @(posedge clock);
      chk("irq lines", 8'({rxIrq, txIrq, emptyIrq}), 8'(i[0] ? 3'h7 : 3'h0));
    end
    wr(ADDR_CTRL, 8'h58);
    @(posedge clock);
    chk("masked irqs", 8'({rxIrq, txIrq, emptyIrq}), 8'h02);
    irqTaken <= 1'b1;
    @(posedge clock);
    irqTaken <= 1'b0;
    repeat (2) @(posedge clock);
    chk("tx irq after taken", 8'(txIrq), 8'h00);
    rc(ADDR_STATUS, 8'ha0);
    rc(ADDR_DATA, rxQ.pop_front());
    wr(ADDR_CTRL, 8'h10);
    wr(ADDR_DATA, 8'(~b));
    repeat (80) @(posedge clock);
    chk("out override tx off", 8'(outOvr), 8'h00);
    rc(ADDR_STATUS, 8'h20);
    tally_and_finish();
  end
endmodule
`default_nettype wire
